/* File: hw/cassette_pkg.sv */
// Constants, register map and state encodings for the cassette read and
// compare controller.
// Assumes a 32-bit AXI4-Lite master and a single 100 MHz clock domain.
package cassette_pkg;

	// Register byte offsets
	localparam logic [4:0]  OFF_CTRL     = 5'h00;
	localparam logic [4:0]  OFF_MODE     = 5'h04;
	localparam logic [4:0]  OFF_STAT     = 5'h08;
	localparam logic [4:0]  OFF_IRQ_STAT = 5'h0c;
	localparam logic [4:0]  OFF_IRQ_MASK = 5'h10;

	// Transfer control word layout
	localparam int unsigned BIT_RD_TRIG  = 1;
	localparam int unsigned BIT_CMP_TRIG = 2;
	localparam int unsigned BIT_MISMATCH = 3;
	localparam int unsigned BIT_ERR_LO   = 12;

	// Transfer error flags, first to last
	localparam int unsigned ERR_W        = 4;
	localparam int unsigned ERR_MODE     = 0;
	localparam int unsigned ERR_SIZE     = 1;
	localparam int unsigned ERR_ABSENT   = 2;
	localparam int unsigned ERR_XFER     = 3;

	// Status word layout
	localparam int unsigned BIT_MODE_LO  = 0;
	localparam int unsigned BIT_BUSY     = 2;
	localparam int unsigned BIT_MEMERR   = 3;
	localparam int unsigned BIT_PRESENT  = 4;
	localparam int unsigned BIT_AUTO_SW  = 5;
	localparam int unsigned BIT_UCODE_SW = 6;

	// Interrupt status and mask layout
	localparam int unsigned IRQ_W        = 3;
	localparam int unsigned IRQ_DONE     = 0;
	localparam int unsigned IRQ_FAULT    = 1;
	localparam int unsigned IRQ_MEMERR   = 2;

	localparam logic [7:0]  FAULT_CODE   = 8'h9d;
	localparam logic [1:0]  BOOT_CYCLES  = 2'h3;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	typedef enum logic [1:0] {
		MODE_PROGRAM = 2'b00,
		MODE_MONITOR = 2'b01,
		MODE_RUN     = 2'b10
	} op_mode_t;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_FETCH   = 3'b001,
		ST_UM_WAIT = 3'b010,
		ST_UM_CHK  = 3'b011,
		ST_FINISH  = 3'b100
	} xfer_state_t;

endpackage : cassette_pkg

/* File: hw/cassette_read_compare_ctrl.sv */
// Cassette to user memory read and cassette compare controller.
// Assumes a cassette word port and a user memory port on aclk; the user
// memory returns read data one cycle after um_re.
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ns
module cassette_read_compare_ctrl #(
	parameter int unsigned UM_WORDS = 16384,
	parameter int unsigned CAS_AW   = 15,
	parameter int unsigned DW       = 16
) (
	// Clock and reset
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	// AXI4-Lite slave
	input  wire logic                    awvalid,
	output logic                         awready,
	input  wire logic [31:0]             awaddr,
	input  wire logic                    wvalid,
	output logic                         wready,
	input  wire logic [31:0]             wdata,
	input  wire logic [3:0]              wstrb,
	output logic                         bvalid,
	input  wire logic                    bready,
	output logic [1:0]                   bresp,
	input  wire logic                    arvalid,
	output logic                         arready,
	input  wire logic [31:0]             araddr,
	output logic                         rvalid,
	input  wire logic                    rready,
	output logic [31:0]                  rdata,
	output logic [1:0]                   rresp,
	// Switches and cassette presence pins
	input  wire logic                    auto_load_sw,
	input  wire logic                    user_codes_sw,
	input  wire logic                    cas_present,
	// Cassette word port
	output logic                         cas_req,
	output logic [CAS_AW-1:0]            cas_addr,
	input  wire logic                    cas_ack,
	input  wire logic                    cas_err,
	input  wire logic [DW-1:0]           cas_rdata,
	input  wire logic [CAS_AW:0]         cas_words,
	// User memory port
	output logic                         um_we,
	output logic                         um_re,
	output logic [CAS_AW-1:0]            um_addr,
	output logic [DW-1:0]                um_wdata,
	input  wire logic [DW-1:0]           um_rdata,
	// Status outputs
	output cassette_pkg::op_mode_t       op_mode,
	output logic                         run_inhibit,
	output logic                         user_codes,
	output logic                         fault_pulse,
	output logic [7:0]                   fault_code,
	output logic                         irq
);
	import cassette_pkg::*;

	// All checks below run on aclk and sleep through reset
	default clocking cb_aclk @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	typedef struct packed {
		xfer_state_t       st;
		logic              rd_trig;
		logic              cmp_trig;
		logic              mismatch;
		logic [ERR_W-1:0]  err;
		logic              mem_error;
		op_mode_t          mode;
		logic              is_boot;
		logic              boot_pending;
		logic [1:0]        boot_cnt;
		logic [CAS_AW:0]   idx;
		logic [DW-1:0]     cas_word;
		logic              differ;
		logic              fault_pulse;
		logic [7:0]        fault_code;
		logic              cas_req;
		logic [CAS_AW-1:0] cas_addr;
		logic              um_we;
		logic              um_re;
		logic [CAS_AW-1:0] um_addr;
		logic [DW-1:0]     um_wdata;
		logic              pres_s1;
		logic              pres_s2;
		logic              auto_s1;
		logic              auto_s2;
		logic              ucode_s1;
		logic              ucode_s2;
		logic [IRQ_W-1:0]  irq_stat;
		logic [IRQ_W-1:0]  irq_mask;
		logic              irq;
		logic              aw_got;
		logic [4:0]        aw_addr;
		logic              w_got;
		logic [31:0]       w_data;
		logic [3:0]        w_strb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
	} state_t;

	state_t s_ff;
	state_t nxt_s;
	logic   start_rd;
	logic   start_cmp;
	logic   fault_now;
	logic   last_chk;

	function automatic logic mapped(input logic [4:0] a);
		return a == OFF_CTRL || a == OFF_MODE || a == OFF_STAT ||
			a == OFF_IRQ_STAT || a == OFF_IRQ_MASK;
	endfunction : mapped

	function automatic logic [CAS_AW:0] step(input logic [CAS_AW:0] i);
		return i + {{CAS_AW{1'b0}}, 1'b1};
	endfunction : step

	always_comb begin
		logic [IRQ_W-1:0] ev;
		logic [IRQ_W-1:0] clr;
		logic [31:0]      rv;
		logic             last;
		logic [CAS_AW:0]  nidx;
		ev = '0;
		clr = '0;
		rv = '0;
		// Selects on a call result are refused, so keep the sum here
		nidx = step(s_ff.idx);
		last = nidx == cas_words;
		start_rd = 1'b0;
		start_cmp = 1'b0;
		fault_now = 1'b0;
		nxt_s = s_ff;
		nxt_s.fault_pulse = 1'b0;
		nxt_s.um_we = 1'b0;
		nxt_s.um_re = 1'b0;
		nxt_s.pres_s1 = cas_present;
		nxt_s.pres_s2 = s_ff.pres_s1;
		nxt_s.auto_s1 = auto_load_sw;
		nxt_s.auto_s2 = s_ff.auto_s1;
		nxt_s.ucode_s1 = user_codes_sw;
		nxt_s.ucode_s2 = s_ff.ucode_s1;

		// Wait for the switch synchronisers to settle before sampling
		if (s_ff.boot_pending) begin
			if (s_ff.boot_cnt != BOOT_CYCLES) begin
				nxt_s.boot_cnt = s_ff.boot_cnt + 2'h1;
			end else begin
				nxt_s.boot_pending = 1'b0;
				if (s_ff.auto_s2) begin
					start_rd = 1'b1;
					nxt_s.is_boot = 1'b1;
				end
			end
		end

		// Write path: address and data held until the response is taken
		if (awvalid && !s_ff.aw_got && !s_ff.bvalid) begin
			nxt_s.aw_got = 1'b1;
			nxt_s.aw_addr = awaddr[4:0];
		end
		if (wvalid && !s_ff.w_got && !s_ff.bvalid) begin
			nxt_s.w_got = 1'b1;
			nxt_s.w_data = wdata;
			nxt_s.w_strb = wstrb;
		end
		if (s_ff.aw_got && s_ff.w_got && !s_ff.bvalid) begin
			nxt_s.bvalid = 1'b1;
			nxt_s.bresp = mapped(s_ff.aw_addr) ? RESP_OKAY : RESP_SLVERR;
			if (s_ff.w_strb[0]) begin
				unique case (s_ff.aw_addr)
				OFF_CTRL: begin
					// Mismatch bit is never written from the bus
					if (s_ff.st == ST_IDLE && !s_ff.boot_pending) begin
						if (s_ff.w_data[BIT_RD_TRIG])
							start_rd = 1'b1;
						else if (s_ff.w_data[BIT_CMP_TRIG])
							start_cmp = 1'b1;
					end
				end
				OFF_MODE: begin
					// Memory error locks the controller in program mode
					if (s_ff.st == ST_IDLE &&
						s_ff.w_data[1:0] != 2'h3 &&
						(!s_ff.mem_error ||
						s_ff.w_data[1:0] == MODE_PROGRAM))
						nxt_s.mode = op_mode_t'(s_ff.w_data[1:0]);
				end
				OFF_IRQ_STAT: clr = s_ff.w_data[IRQ_W-1:0];
				OFF_IRQ_MASK: nxt_s.irq_mask = s_ff.w_data[IRQ_W-1:0];
				default: ;
				endcase
			end
		end
		if (s_ff.bvalid && bready) begin
			nxt_s.bvalid = 1'b0;
			nxt_s.aw_got = 1'b0;
			nxt_s.w_got = 1'b0;
		end

		// Read path
		if (arvalid && !s_ff.rvalid) begin
			unique case (araddr[4:0])
			OFF_CTRL: begin
				rv[BIT_RD_TRIG] = s_ff.rd_trig;
				rv[BIT_CMP_TRIG] = s_ff.cmp_trig;
				rv[BIT_MISMATCH] = s_ff.mismatch;
				rv[BIT_ERR_LO +: ERR_W] = s_ff.err;
			end
			OFF_MODE: rv[1:0] = s_ff.mode;
			OFF_STAT: begin
				rv[BIT_MODE_LO +: 2] = s_ff.mode;
				rv[BIT_BUSY] = s_ff.st != ST_IDLE;
				rv[BIT_MEMERR] = s_ff.mem_error;
				rv[BIT_PRESENT] = s_ff.pres_s2;
				rv[BIT_AUTO_SW] = s_ff.auto_s2;
				rv[BIT_UCODE_SW] = s_ff.ucode_s2;
			end
			OFF_IRQ_STAT: rv[IRQ_W-1:0] = s_ff.irq_stat;
			OFF_IRQ_MASK: rv[IRQ_W-1:0] = s_ff.irq_mask;
			default: ;
			endcase
			nxt_s.rvalid = 1'b1;
			nxt_s.rdata = rv;
			nxt_s.rresp = mapped(araddr[4:0]) ? RESP_OKAY : RESP_SLVERR;
		end
		if (s_ff.rvalid && rready)
			nxt_s.rvalid = 1'b0;

		// Launch checks; error flags of the previous operation are replaced
		if (start_rd || start_cmp) begin
			nxt_s.err = '0;
			if (s_ff.mode != MODE_PROGRAM) begin
				nxt_s.err[ERR_MODE] = 1'b1;
				nxt_s.mismatch = start_cmp ? 1'b1 : s_ff.mismatch;
				fault_now = 1'b1;
				ev[IRQ_DONE] = 1'b1;
			end else if (!s_ff.pres_s2 || cas_words == '0) begin
				nxt_s.err[ERR_ABSENT] = 1'b1;
				if (start_cmp)
					nxt_s.mismatch = 1'b1;
				else
					fault_now = 1'b1;
				ev[IRQ_DONE] = 1'b1;
			end else if (32'(cas_words) > UM_WORDS) begin
				// Image larger than user memory is refused whole
				nxt_s.err[ERR_SIZE] = 1'b1;
				nxt_s.mismatch = start_cmp ? 1'b1 : s_ff.mismatch;
				fault_now = 1'b1;
				ev[IRQ_DONE] = 1'b1;
			end else begin
				nxt_s.st = ST_FETCH;
				nxt_s.rd_trig = start_rd;
				nxt_s.cmp_trig = start_cmp;
				nxt_s.idx = '0;
				nxt_s.differ = 1'b0;
				nxt_s.cas_req = 1'b1;
				nxt_s.cas_addr = '0;
			end
		end

		unique case (s_ff.st)
		ST_IDLE: ;
		ST_FETCH: begin
			// Same word handshake whatever the cassette technology
			if (cas_ack) begin
				nxt_s.cas_req = 1'b0;
				if (cas_err) begin
					nxt_s.err[ERR_XFER] = 1'b1;
					nxt_s.differ = 1'b1;
					fault_now = 1'b1;
					nxt_s.st = ST_FINISH;
				end else if (s_ff.rd_trig) begin
					// Only this engine writes user memory
					nxt_s.um_we = 1'b1;
					nxt_s.um_addr = s_ff.idx[CAS_AW-1:0];
					nxt_s.um_wdata = cas_rdata;
					if (last) begin
						nxt_s.st = ST_FINISH;
					end else begin
						nxt_s.idx = nidx;
						nxt_s.cas_addr = nidx[CAS_AW-1:0];
						nxt_s.cas_req = 1'b1;
					end
				end else begin
					nxt_s.cas_word = cas_rdata;
					nxt_s.um_re = 1'b1;
					nxt_s.um_addr = s_ff.idx[CAS_AW-1:0];
					nxt_s.st = ST_UM_WAIT;
				end
			end
		end
		ST_UM_WAIT: nxt_s.st = ST_UM_CHK;
		ST_UM_CHK: begin
			if (um_rdata != s_ff.cas_word)
				nxt_s.differ = 1'b1;
			if (last) begin
				nxt_s.st = ST_FINISH;
			end else begin
				nxt_s.idx = nidx;
				nxt_s.cas_addr = nidx[CAS_AW-1:0];
				nxt_s.cas_req = 1'b1;
				nxt_s.st = ST_FETCH;
			end
		end
		ST_FINISH: begin
			nxt_s.rd_trig = 1'b0;
			nxt_s.cmp_trig = 1'b0;
			if (s_ff.cmp_trig)
				nxt_s.mismatch = s_ff.differ;
			nxt_s.is_boot = 1'b0;
			ev[IRQ_DONE] = 1'b1;
			nxt_s.st = ST_IDLE;
		end
		default: nxt_s.st = ST_IDLE;
		endcase

		if (fault_now) begin
			nxt_s.fault_pulse = 1'b1;
			nxt_s.fault_code = FAULT_CODE;
			ev[IRQ_FAULT] = 1'b1;
			if (s_ff.is_boot || (start_rd && s_ff.boot_pending)) begin
				nxt_s.mem_error = 1'b1;
				nxt_s.mode = MODE_PROGRAM;
				ev[IRQ_MEMERR] = 1'b1;
			end
		end

		// New events win over a simultaneous clear
		nxt_s.irq_stat = (s_ff.irq_stat & ~clr) | ev;
		nxt_s.irq = |(nxt_s.irq_stat & nxt_s.irq_mask);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_ff <= '0;
			s_ff.st <= ST_IDLE;
			s_ff.mode <= MODE_PROGRAM;
			s_ff.boot_pending <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign awready = !s_ff.aw_got && !s_ff.bvalid;
	assign wready = !s_ff.w_got && !s_ff.bvalid;
	assign bvalid = s_ff.bvalid;
	assign bresp = s_ff.bresp;
	assign arready = !s_ff.rvalid;
	assign rvalid = s_ff.rvalid;
	assign rdata = s_ff.rdata;
	assign rresp = s_ff.rresp;
	assign cas_req = s_ff.cas_req;
	assign cas_addr = s_ff.cas_addr;
	assign um_we = s_ff.um_we;
	assign um_re = s_ff.um_re;
	assign um_addr = s_ff.um_addr;
	assign um_wdata = s_ff.um_wdata;
	assign op_mode = s_ff.mode;
	assign run_inhibit = s_ff.mem_error;
	assign user_codes = s_ff.ucode_s2;
	assign fault_pulse = s_ff.fault_pulse;
	assign fault_code = s_ff.fault_code;
	assign irq = s_ff.irq;

	assign last_chk = step(s_ff.idx) == cas_words;

	a_trig_self_clear: assert property (
		s_ff.st == ST_FINISH |=> !s_ff.rd_trig && !s_ff.cmp_trig
		&& s_ff.st == ST_IDLE)
		else $error("trigger not cleared after finish");
	a_one_at_time: assert property (
		s_ff.st != ST_IDLE |-> !start_rd && !start_cmp)
		else $error("operation launched while busy");
	a_mode_skip: assert property (
		start_cmp && s_ff.mode != MODE_PROGRAM |=> s_ff.mismatch
		&& s_ff.err[ERR_MODE] && fault_pulse && s_ff.st == ST_IDLE)
		else $error("compare outside program mode not refused");
	a_absent_flag: assert property (
		start_cmp && s_ff.mode == MODE_PROGRAM && !s_ff.pres_s2
		|=> s_ff.mismatch)
		else $error("missing cassette did not set mismatch");
	a_flag_source: assert property (
		$changed(s_ff.mismatch) |-> $past(s_ff.st) == ST_FINISH
		|| $past(start_cmp))
		else $error("mismatch flag changed without a compare");
	a_xfer_fault: assert property (
		s_ff.st == ST_FETCH && cas_ack && cas_err |=> fault_pulse
		&& fault_code == FAULT_CODE && s_ff.err[ERR_XFER] ##1 !fault_pulse)
		else $error("transfer fault not reported");
	a_boot_memerr: assert property (
		s_ff.is_boot && s_ff.st == ST_FETCH && cas_ack && cas_err
		|=> run_inhibit [*3])
		else $error("power-up fault did not inhibit run");
	a_copy_word: assert property (
		s_ff.st == ST_FETCH && s_ff.rd_trig && cas_ack && !cas_err
		|=> um_we && um_wdata == $past(cas_rdata)
		&& um_addr == $past(s_ff.idx[CAS_AW-1:0]))
		else $error("cassette word not copied to memory");
	a_cmp_result: assert property (
		s_ff.st == ST_UM_CHK && um_rdata != s_ff.cas_word && last_chk
		|=> ##1 s_ff.mismatch)
		else $error("differing word did not give mismatch");
	a_boot_start: assert property (
		s_ff.boot_pending && s_ff.boot_cnt == BOOT_CYCLES && s_ff.auto_s2
		&& s_ff.mode == MODE_PROGRAM && s_ff.pres_s2 && cas_words != '0
		&& 32'(cas_words) <= UM_WORDS
		|=> s_ff.st == ST_FETCH && s_ff.rd_trig)
		else $error("auto load did not start at power-up");

endmodule : cassette_read_compare_ctrl

/* File: dv/cassette_partner.sv */
// Behavioural cassette and user memory facing the controller.
// Assumes the controller's word handshake and two-edge user memory read.
`timescale 1ns/1ns
module cassette_partner (
	// Clock
	input  wire logic        aclk,
	// Bench controls
	input  wire logic [3:0]  lat,
	input  wire logic [15:0] salt,
	input  wire logic [15:0] err_at,
	input  wire logic        flip,
	// Cassette word port
	input  wire logic        cas_req,
	input  wire logic [14:0] cas_addr,
	output logic             cas_ack,
	output logic             cas_err,
	output logic [15:0]      cas_rdata,
	// User memory port
	input  wire logic        um_we,
	input  wire logic        um_re,
	input  wire logic [14:0] um_addr,
	input  wire logic [15:0] um_wdata,
	output logic [15:0]      um_rdata
);
	logic [15:0] mem [0:15];
	logic [3:0]  wait_cnt = 4'h0;

	initial begin
		cas_ack   = 1'b0;
		cas_err   = 1'b0;
		cas_rdata = 16'h0;
		um_rdata  = 16'h0;
	end

	// Same image whatever the memory technology; only latency varies
	always @(posedge aclk) begin
		cas_ack   <= 1'b0;
		cas_err   <= 1'b0;
		// Released data bus toggles every cycle, so it shows the last word only on alternate cycles
		cas_rdata <= ~cas_rdata;
		if (cas_req && !cas_ack) begin
			if (wait_cnt >= lat) begin
				wait_cnt  <= 4'h0;
				cas_ack   <= 1'b1;
				cas_err   <= ({1'b0, cas_addr} == err_at);
				cas_rdata <= salt ^ {1'b0, cas_addr}
					^ {15'h0, flip && cas_addr == 15'h1};
			end else begin
				wait_cnt <= wait_cnt + 4'h1;
			end
		end
		if (um_we)
			mem[um_addr[3:0]] <= um_wdata;
		um_rdata <= um_re ? mem[um_addr[3:0]] : ~um_rdata;
	end
endmodule : cassette_partner

/* File: dv/tb_top.sv */
// Self-checking bench for the cassette read and compare controller.
// Assumes cassette_partner stands in for cassette and user memory.
`timescale 1ns/1ns
module tb_top;
	import cassette_pkg::*;
	logic        aclk = 1'b0, aresetn = 1'b0, auto_load_sw = 1'b1;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0, flip = 1'b0;
	logic        user_codes_sw = 1'b0, cas_present = 1'b1;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
	logic [15:0] cas_words = 16'h8, salt = 16'h1234, err_at = 16'hffff;
	logic [3:0]  lat = 4'h0;
	logic        awready, wready, bvalid, arready, rvalid, cas_req, cas_ack;
	logic        cas_err, um_we, um_re, run_inhibit, user_codes;
	logic        fault_pulse, irq;
	logic [31:0] rdata, rv;
	logic [1:0]  bresp, rresp, resp;
	logic [14:0] cas_addr, um_addr;
	logic [15:0] cas_rdata, um_wdata, um_rdata;
	logic [7:0]  fault_code;
	op_mode_t    op_mode;
	int          failures = 0, compares = 0, faults = 0, acks = 0, snap;

	always #5 aclk = ~aclk;

	cassette_read_compare_ctrl #(.UM_WORDS(8)) cassette_read_compare_ctrl_inst (
		.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
		.wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.auto_load_sw(auto_load_sw), .user_codes_sw(user_codes_sw),
		.cas_present(cas_present), .cas_req(cas_req), .cas_addr(cas_addr),
		.cas_ack(cas_ack), .cas_err(cas_err), .cas_rdata(cas_rdata),
		.cas_words(cas_words), .um_we(um_we), .um_re(um_re),
		.um_addr(um_addr), .um_wdata(um_wdata), .um_rdata(um_rdata),
		.op_mode(op_mode), .run_inhibit(run_inhibit),
		.user_codes(user_codes), .fault_pulse(fault_pulse),
		.fault_code(fault_code), .irq(irq));

	cassette_partner cassette_partner_inst (
		.aclk(aclk), .lat(lat), .salt(salt), .err_at(err_at), .flip(flip),
		.cas_req(cas_req), .cas_addr(cas_addr), .cas_ack(cas_ack),
		.cas_err(cas_err), .cas_rdata(cas_rdata), .um_we(um_we),
		.um_re(um_re), .um_addr(um_addr), .um_wdata(um_wdata),
		.um_rdata(um_rdata));

	// Mid-cycle view of one-cycle outputs
	always @(negedge aclk) begin
		if (fault_pulse === 1'b1)
			faults++;
		if (cas_ack === 1'b1 && cas_req === 1'b1)
			acks++;
	end

	task automatic finish_test();
		$display("failures %0d compares %0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic timeout();
		failures++;
		$display("unexpected wait: expected answer seen none");
		finish_test();
	endtask : timeout

	// Handshake decided on mid-cycle values, released after the edge
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic ah, wh, bh;
		@(posedge aclk);
		awvalid <= 1'b1;
		awaddr  <= {27'h0, a};
		wvalid  <= 1'b1;
		wdata   <= d;
		bready  <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(negedge aclk);
			ah   = awvalid && awready;
			wh   = wvalid && wready;
			bh   = bvalid && bready;
			resp = bresp;
			@(posedge aclk);
			if (ah)
				awvalid <= 1'b0;
			if (wh)
				wvalid <= 1'b0;
			if (bh) begin
				bready <= 1'b0;
				return;
			end
		end
		timeout();
	endtask : wr

	task automatic rd(input logic [4:0] a);
		logic ah, dh;
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr  <= {27'h0, a};
		rready  <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(negedge aclk);
			ah   = arvalid && arready;
			dh   = rvalid && rready;
			rv   = rdata;
			resp = rresp;
			@(posedge aclk);
			if (ah)
				arvalid <= 1'b0;
			if (dh) begin
				rready <= 1'b0;
				return;
			end
		end
		timeout();
	endtask : rd

	task automatic rd_chk(input string nm, input logic [4:0] a,
		input logic [31:0] exp);
		rd(a);
		chk(nm, rv, exp);
	endtask : rd_chk

	task automatic wait_idle();
		for (int n = 0; n < 200; n++) begin
			rd(OFF_STAT);
			if (rv[BIT_BUSY] === 1'b0)
				return;
		end
		timeout();
	endtask : wait_idle

	task automatic rst(input logic al);
		@(posedge aclk);
		aresetn      <= 1'b0;
		auto_load_sw <= al;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (8) @(posedge aclk);
		wait_idle();
	endtask : rst

	task automatic mem_chk(input logic [15:0] s);
		for (int i = 0; i < 8; i++)
			chk("um word", {16'h0, cassette_partner_inst.mem[i]},
				{16'h0, s ^ 16'(i)});
	endtask : mem_chk

	task automatic op(input logic [31:0] trig, input logic [31:0] exp);
		wr(OFF_CTRL, trig);
		wait_idle();
		rd_chk("control word", OFF_CTRL, exp);
	endtask : op

	initial begin
		rst(1'b1);
		mem_chk(16'h1234);
		rd_chk("mode", OFF_MODE, 32'h0);
		rd_chk("irq mask", OFF_IRQ_MASK, 32'h0);
		wr(5'h14, 32'h1);
		chk("unmapped bresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
		rd(5'h14);
		chk("unmapped rresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
		user_codes_sw <= 1'b1;
		repeat (4) @(posedge aclk);
		chk("user codes", {31'h0, user_codes}, 32'h1);
		salt <= 16'h5a00;
		snap = acks;
		wr(OFF_CTRL, 32'h2);
		wr(OFF_CTRL, 32'h4);
		wait_idle();
		rd_chk("control word", OFF_CTRL, 32'h0);
		chk("word count", 32'(acks - snap), 32'h8);
		mem_chk(16'h5a00);
		rd(OFF_IRQ_STAT);
		chk("done bit", {31'h0, rv[IRQ_DONE]}, 32'h1);
		wr(OFF_IRQ_MASK, 32'h1);
		@(negedge aclk);
		chk("irq", {31'h0, irq}, 32'h1);
		wr(OFF_IRQ_STAT, 32'h1);
		@(negedge aclk);
		chk("irq", {31'h0, irq}, 32'h0);
		op(32'h4, 32'h0);
		op(32'h8, 32'h0);
		lat  <= 4'h5;
		flip <= 1'b1;
		op(32'h4, 32'h1 << BIT_MISMATCH);
		flip <= 1'b0;
		op(32'h4, 32'h0);
		err_at <= 16'h3;
		snap = faults;
		op(32'h2, 32'h1 << (BIT_ERR_LO + ERR_XFER));
		chk("fault code", {24'h0, fault_code}, {24'h0, FAULT_CODE});
		chk("fault pulses", 32'(faults - snap), 32'h1);
		err_at    <= 16'hffff;
		cas_words <= 16'h9;
		op(32'h2, 32'h1 << (BIT_ERR_LO + ERR_SIZE));
		cas_words <= 16'h8;
		wr(OFF_MODE, {30'h0, MODE_MONITOR});
		chk("op mode", {30'h0, op_mode}, {30'h0, MODE_MONITOR});
		op(32'h2, 32'h1 << (BIT_ERR_LO + ERR_MODE));
		wr(OFF_MODE, {30'h0, MODE_RUN});
		op(32'h4, (32'h1 << (BIT_ERR_LO + ERR_MODE)) |
			(32'h1 << BIT_MISMATCH));
		wr(OFF_MODE, {30'h0, MODE_PROGRAM});
		cas_present <= 1'b0;
		repeat (4) @(posedge aclk);
		op(32'h4, (32'h1 << (BIT_ERR_LO + ERR_ABSENT)) |
			(32'h1 << BIT_MISMATCH));
		cas_present <= 1'b1;
		err_at      <= 16'h2;
		rst(1'b1);
		rd(OFF_STAT);
		chk("memory error", {31'h0, rv[BIT_MEMERR]}, 32'h1);
		chk("run inhibit", {31'h0, run_inhibit}, 32'h1);
		wr(OFF_MODE, {30'h0, MODE_RUN});
		rd_chk("mode", OFF_MODE, 32'h0);
		rd(OFF_IRQ_STAT);
		chk("memory error irq", {31'h0, rv[IRQ_MEMERR]}, 32'h1);
		chk("op mode", {30'h0, op_mode}, {30'h0, MODE_PROGRAM});
		finish_test();
	end
endmodule : tb_top
